//--- psol_strap_latch.sv
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module psol_strap_latch
   import psol_pkg::*;
(
   // Clock and chip reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [4:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Normal pin functions from the receive path and the interrupt
   input wire logic [3:0] rx_data_i,
   input wire logic rx_clk_func_i,
   input wire logic rx_valid_i,
   input wire logic rx_error_i,
   input wire logic carrier_i,
   input wire logic irq_active_i,
   // Shared pins: receive data 3..1 / address straps
   input wire logic mgmt_addr_strap_bit0_i,
   output logic mgmt_addr_strap_bit0_o,
   output logic mgmt_addr_strap_bit0_oe_o,
   input wire logic mgmt_addr_strap_bit1_i,
   output logic mgmt_addr_strap_bit1_o,
   output logic mgmt_addr_strap_bit1_oe_o,
   input wire logic mgmt_addr_strap_bit2_i,
   output logic mgmt_addr_strap_bit2_o,
   output logic mgmt_addr_strap_bit2_oe_o,
   // Shared pin: receive data 0 / auto-negotiation strap
   input wire logic strap_a_i,
   output logic strap_a_o,
   output logic strap_a_oe_o,
   // Shared pins: receive clock, carrier, data valid / mode straps
   input wire logic mode_select_strap_bit0_i,
   output logic mode_select_strap_bit0_o,
   output logic mode_select_strap_bit0_oe_o,
   input wire logic mode_select_strap_bit1_i,
   output logic mode_select_strap_bit1_o,
   output logic mode_select_strap_bit1_oe_o,
   input wire logic mode_select_strap_bit2_i,
   output logic mode_select_strap_bit2_o,
   output logic mode_select_strap_bit2_oe_o,
   // Shared pin: receive error / emission filter strap
   input wire logic emission_filter_strap_i,
   output logic emission_filter_strap_o,
   output logic emission_filter_strap_oe_o,
   // Shared pin: interrupt, open-drain like / connectivity-test strap
   input wire logic interrupt_out_i,
   output logic interrupt_out_o,
   output logic interrupt_out_oe_o,
   // Configuration to the rest of the chip
   output logic [4:0] mgmt_addr_o,
   output logic [2:0] mode_code_o,
   output var psol_if_mode_t if_mode_o,
   output logic auto_xover_o,
   output logic strap_a_en_o,
   output logic nand_tree_en_o,
   output logic emission_filter_en_o
);

   psol_phase_t phase_reg;
   logic [2:0] addr_cap_reg;
   logic [2:0] mode_cap_reg;
   logic aneg_cap_reg;
   logic nand_cap_reg;
   logic filt_cap_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] rdata_reg;
   logic [15:0] stat_word;
   logic pin_drive;
   logic [8:0] pin_out_reg;

   function automatic psol_if_mode_t decode_if(input logic [2:0] code);
      case (code)
         PSOL_MODE_MII_PLAIN: decode_if = PSOL_IF_NORMAL;
         PSOL_MODE_MII_XOVER: decode_if = PSOL_IF_NORMAL;
         PSOL_MODE_B2B_XOVER: decode_if = PSOL_IF_B2B;
         default: decode_if = PSOL_IF_RESERVED;
      endcase
   endfunction

   function automatic logic decode_xover(input logic [2:0] code);
      decode_xover = (code == PSOL_MODE_MII_XOVER) ||
         (code == PSOL_MODE_B2B_XOVER);
   endfunction

   // Pins are released from the first clock edge in reset until one cycle past it,
   // so the last reset cycle sees only pulls and board resistors
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg <= PSOL_PH_STRAP;
      end else begin
         phase_reg <= PSOL_PH_RUN;
      end
   end

   assign pin_drive = (phase_reg == PSOL_PH_RUN);

   // Captures track the pins while reset is held; the value of the last
   // reset cycle is what remains at release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_cap_reg <= {mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit1_i,
            mgmt_addr_strap_bit0_i};
         mode_cap_reg <= {mode_select_strap_bit2_i, mode_select_strap_bit1_i,
            mode_select_strap_bit0_i};
         aneg_cap_reg <= strap_a_i;
         nand_cap_reg <= interrupt_out_i;
         filt_cap_reg <= emission_filter_strap_i;
      end
      // Otherwise frozen until the next chip reset
   end

   // Control register: strap loads bit 12 inverted, software may rewrite
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= PSOL_CTRL_RST;
         ctrl_reg[PSOL_CTRL_ANEG_BIT] <= ~strap_a_i;
      end else if (reg_wr_i && reg_addr_i == PSOL_REG_BASIC_CTRL) begin
         ctrl_reg <= reg_wdata_i;
      end
   end

   always_comb begin
      stat_word = 16'h0000;
      stat_word[PSOL_STAT_ADDR_LSB +: 5] = mgmt_addr_o;
      stat_word[PSOL_STAT_MODE_LSB +: 3] = mode_cap_reg;
      stat_word[PSOL_STAT_ANEG_RAW_BIT] = aneg_cap_reg;
      stat_word[PSOL_STAT_NAND_BIT] = nand_tree_en_o;
      stat_word[PSOL_STAT_FILT_BIT] = emission_filter_en_o;
      stat_word[PSOL_STAT_RSVD_BIT] = (if_mode_o == PSOL_IF_RESERVED);
   end

   // Read data stand one cycle after the strobe only; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i || !reg_rd_i) begin
         rdata_reg <= 16'h0000;
      end else begin
         case (reg_addr_i)
            PSOL_REG_BASIC_CTRL: rdata_reg <= ctrl_reg;
            PSOL_REG_STRAP_STAT: rdata_reg <= stat_word;
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end

   assign reg_rdata_o = rdata_reg;

   // Normal pin functions, registered; zero while reset is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_reg <= 9'h000;
      end else begin
         pin_out_reg <= {1'b0, rx_error_i, rx_valid_i, carrier_i,
            rx_clk_func_i, rx_data_i};
      end
   end

   assign strap_a_o = pin_out_reg[0];
   assign mgmt_addr_strap_bit2_o = pin_out_reg[1];
   assign mgmt_addr_strap_bit1_o = pin_out_reg[2];
   assign mgmt_addr_strap_bit0_o = pin_out_reg[3];
   assign mode_select_strap_bit0_o = pin_out_reg[4];
   assign mode_select_strap_bit1_o = pin_out_reg[5];
   assign mode_select_strap_bit2_o = pin_out_reg[6];
   assign emission_filter_strap_o = pin_out_reg[7];
   // Open-drain like: only ever pulls low
   assign interrupt_out_o = pin_out_reg[8];

   assign strap_a_oe_o = pin_drive;
   assign mgmt_addr_strap_bit0_oe_o = pin_drive;
   assign mgmt_addr_strap_bit1_oe_o = pin_drive;
   assign mgmt_addr_strap_bit2_oe_o = pin_drive;
   assign mode_select_strap_bit0_oe_o = pin_drive;
   assign mode_select_strap_bit1_oe_o = pin_drive;
   assign mode_select_strap_bit2_oe_o = pin_drive;
   assign emission_filter_strap_oe_o = pin_drive;
   // Active-low interrupt; a board pull-up gives the high level
   assign interrupt_out_oe_o = pin_drive && irq_active_i;

   assign mgmt_addr_o = {PSOL_ADDR_UPPER, addr_cap_reg};
   assign mode_code_o = mode_cap_reg;
   assign if_mode_o = decode_if(mode_cap_reg);
   // Reserved codes give no crossover; safest fallback
   assign auto_xover_o = decode_xover(mode_cap_reg);
   assign strap_a_en_o = ctrl_reg[PSOL_CTRL_ANEG_BIT];
   assign nand_tree_en_o = ~nand_cap_reg;
   assign emission_filter_en_o = ~filt_cap_reg;

   // Checks
   sequence s_release;
      $fell(rst_i);
   endsequence

   sequence s_held;
      !rst_i && !$fell(rst_i);
   endsequence

   property p_upper_zero;
      @(posedge clk_i) disable iff (rst_i)
         mgmt_addr_o[4:3] == PSOL_ADDR_UPPER;
   endproperty

   chk_addr_upper: assert property (p_upper_zero)
      else $error("address upper bits not zero");

   chk_addr_capture: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release |-> mgmt_addr_o[2:0] == {$past(mgmt_addr_strap_bit2_i),
      $past(mgmt_addr_strap_bit1_i), $past(mgmt_addr_strap_bit0_i)})
      else $error("address not taken from last reset cycle");

   chk_mode_decode: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release |-> mode_code_o == {$past(mode_select_strap_bit2_i),
      $past(mode_select_strap_bit1_i), $past(mode_select_strap_bit0_i)}
      && (auto_xover_o == (mode_code_o == PSOL_MODE_MII_XOVER ||
      mode_code_o == PSOL_MODE_B2B_XOVER))
      && ((if_mode_o == PSOL_IF_B2B) ==
      (mode_code_o == PSOL_MODE_B2B_XOVER)))
      else $error("mode strap capture or decode wrong");

   chk_aneg_invert: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release |-> strap_a_en_o == !$past(strap_a_i)
      && ctrl_reg[PSOL_CTRL_ANEG_BIT] == !$past(strap_a_i))
      else $error("auto-negotiation strap not inverted into bit 12");

   chk_aneg_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == PSOL_REG_BASIC_CTRL |=> strap_a_en_o ==
      $past(reg_wdata_i[PSOL_CTRL_ANEG_BIT]))
      else $error("control write did not steer auto-negotiation");

   chk_nand_capture: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release |-> nand_tree_en_o == !$past(interrupt_out_i))
      else $error("connectivity-test strap capture wrong");

   chk_filter_capture: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release |-> emission_filter_en_o ==
      !$past(emission_filter_strap_i))
      else $error("emission filter strap capture wrong");

   chk_pins_released: assert property (
      @(posedge clk_i)
      rst_i |=> !strap_a_oe_o && !mgmt_addr_strap_bit0_oe_o &&
      !mode_select_strap_bit2_oe_o && !emission_filter_strap_oe_o &&
      !interrupt_out_oe_o)
      else $error("strap pin driven during reset");

   chk_pins_driven: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_release ##1 !rst_i |-> strap_a_oe_o && mode_select_strap_bit1_oe_o
      && mgmt_addr_strap_bit2_oe_o && emission_filter_strap_oe_o)
      else $error("pins not driven one cycle after release");

   chk_pin_function: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_held ##1 !rst_i |-> strap_a_o == $past(rx_data_i[0]) &&
      emission_filter_strap_o == $past(rx_error_i))
      else $error("pin does not carry its normal function");

   chk_hold_stable: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_held |-> $stable(mgmt_addr_o) && $stable(mode_code_o) &&
      $stable(nand_tree_en_o) && $stable(emission_filter_en_o))
      else $error("latched strap changed outside reset");

   chk_read_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == PSOL_REG_STRAP_STAT |=>
      reg_rdata_o[4:0] == mgmt_addr_o
      && reg_rdata_o[PSOL_STAT_NAND_BIT] == nand_tree_en_o)
      else $error("status read does not show latched straps");

endmodule

`default_nettype wire

//--- psol_pkg.sv
package psol_pkg;

   // Register map, 5-bit management register address
   localparam logic [4:0] PSOL_REG_BASIC_CTRL = 5'h00;
   localparam logic [4:0] PSOL_REG_STRAP_STAT = 5'h1e;

   // Basic control register
   localparam int PSOL_CTRL_ANEG_BIT = 12;
   localparam logic [15:0] PSOL_CTRL_RST = 16'h0000;

   // Strap status register layout
   localparam int PSOL_STAT_ADDR_LSB = 0;
   localparam int PSOL_STAT_MODE_LSB = 5;
   localparam int PSOL_STAT_ANEG_RAW_BIT = 8;
   localparam int PSOL_STAT_NAND_BIT = 9;
   localparam int PSOL_STAT_FILT_BIT = 10;
   localparam int PSOL_STAT_RSVD_BIT = 11;

   // Management address: fixed upper bits
   localparam logic [1:0] PSOL_ADDR_UPPER = 2'h0;

   // Internal pull levels, the value taken with nothing on the pin
   localparam logic PSOL_PULL_ADDR0 = 1'h1;
   localparam logic PSOL_PULL_ADDR1 = 1'h0;
   localparam logic PSOL_PULL_ADDR2 = 1'h0;
   localparam logic PSOL_PULL_MODE = 1'h0;
   localparam logic PSOL_PULL_ANEG = 1'h1;
   localparam logic PSOL_PULL_NAND = 1'h1;
   localparam logic PSOL_PULL_FILT = 1'h0;

   // Mode-select codes
   localparam logic [2:0] PSOL_MODE_MII_PLAIN = 3'h0;
   localparam logic [2:0] PSOL_MODE_MII_XOVER = 3'h2;
   localparam logic [2:0] PSOL_MODE_B2B_XOVER = 3'h6;

   typedef enum logic [1:0] {
      PSOL_IF_NORMAL = 2'h0,
      PSOL_IF_B2B = 2'h1,
      PSOL_IF_RESERVED = 2'h3
   } psol_if_mode_t;

   // Pin phase, Gray along reset -> run
   typedef enum logic [1:0] {
      PSOL_PH_STRAP = 2'h0,
      PSOL_PH_RUN = 2'h1
   } psol_phase_t;

endpackage

//--- psol_board_model.sv
`timescale 1ns/1ns
`default_nettype none

module psol_board_model
   import psol_pkg::*;
(
   // Device side of each shared pin
   input wire logic [8:0] dev_o_i,
   input wire logic [8:0] dev_oe_i,
   // Board resistors, fitted mask and level
   input wire logic [8:0] fit_i,
   input wire logic [8:0] val_i,
   // Resolved wire levels
   output logic [8:0] pin_o
);
   localparam logic [8:0] PULLS = {PSOL_PULL_FILT, PSOL_PULL_NAND,
      PSOL_PULL_ANEG, {3{PSOL_PULL_MODE}}, PSOL_PULL_ADDR2,
      PSOL_PULL_ADDR1, PSOL_PULL_ADDR0};

   // MAC never drives in reset, so only resistors or pulls decide
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         pin_o[i] = dev_oe_i[i] ? dev_o_i[i] :
            (fit_i[i] ? val_i[i] : PULLS[i]);
      end
   end
endmodule

`default_nettype wire

//--- phy_strap_option_latch_test.sv
`timescale 1ns/1ns
`default_nettype none

module phy_strap_option_latch_test;
   import psol_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] reg_addr_i = 5'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [3:0] rx_d = 4'ha;
   logic rx_c = 1'b1;
   logic rx_v = 1'b0;
   logic rx_e = 1'b1;
   logic crs = 1'b1;
   logic irq = 1'b1;
   logic [8:0] fit = 9'h000;
   logic [8:0] val = 9'h000;
   wire logic [15:0] reg_rdata_o;
   wire logic [8:0] o_v;
   wire logic [8:0] oe_v;
   wire logic [8:0] pin_w;
   wire logic [4:0] addr_o;
   wire logic [2:0] mode_o;
   psol_if_mode_t ifm_o;
   wire logic xo_o, an_o, nt_o, ef_o;
   int n_errors = 0;
   int compares = 0;
   // Row: {xover, if mode, filter, nand, strap_a, mode, addr}
   logic [11:0] rows [8] = '{
      {1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 3'h0, 3'h1},
      {1'b0, 2'h3, 1'b1, 1'b0, 1'b0, 3'h1, 3'h7},
      {1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 3'h2, 3'h0},
      {1'b0, 2'h3, 1'b1, 1'b1, 1'b0, 3'h3, 3'h2},
      {1'b0, 2'h3, 1'b1, 1'b1, 1'b1, 3'h4, 3'h4},
      {1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 3'h5, 3'h5},
      {1'b1, 2'h1, 1'b1, 1'b0, 1'b1, 3'h6, 3'h6},
      {1'b0, 2'h3, 1'b0, 1'b1, 1'b0, 3'h7, 3'h3}};
   wire logic [15:0] cfg = {addr_o, mode_o, ifm_o, xo_o, an_o, nt_o, ef_o,
      2'h0};

   always #50 clk_i = ~clk_i;

   psol_strap_latch u_dut(.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .rx_data_i(rx_d), .rx_clk_func_i(rx_c), .rx_valid_i(rx_v),
      .rx_error_i(rx_e), .carrier_i(crs), .irq_active_i(irq),
      .mgmt_addr_strap_bit0_i(pin_w[0]), .mgmt_addr_strap_bit0_o(o_v[0]),
      .mgmt_addr_strap_bit0_oe_o(oe_v[0]),
      .mgmt_addr_strap_bit1_i(pin_w[1]), .mgmt_addr_strap_bit1_o(o_v[1]),
      .mgmt_addr_strap_bit1_oe_o(oe_v[1]),
      .mgmt_addr_strap_bit2_i(pin_w[2]), .mgmt_addr_strap_bit2_o(o_v[2]),
      .mgmt_addr_strap_bit2_oe_o(oe_v[2]),
      .mode_select_strap_bit0_i(pin_w[3]), .mode_select_strap_bit0_o(o_v[3]),
      .mode_select_strap_bit0_oe_o(oe_v[3]),
      .mode_select_strap_bit1_i(pin_w[4]), .mode_select_strap_bit1_o(o_v[4]),
      .mode_select_strap_bit1_oe_o(oe_v[4]),
      .mode_select_strap_bit2_i(pin_w[5]), .mode_select_strap_bit2_o(o_v[5]),
      .mode_select_strap_bit2_oe_o(oe_v[5]),
      .strap_a_i(pin_w[6]), .strap_a_o(o_v[6]), .strap_a_oe_o(oe_v[6]),
      .interrupt_out_i(pin_w[7]), .interrupt_out_o(o_v[7]),
      .interrupt_out_oe_o(oe_v[7]),
      .emission_filter_strap_i(pin_w[8]), .emission_filter_strap_o(o_v[8]),
      .emission_filter_strap_oe_o(oe_v[8]),
      .mgmt_addr_o(addr_o), .mode_code_o(mode_o), .if_mode_o(ifm_o),
      .auto_xover_o(xo_o), .strap_a_en_o(an_o), .nand_tree_en_o(nt_o),
      .emission_filter_en_o(ef_o));

   psol_board_model u_board(.dev_o_i(o_v), .dev_oe_i(oe_v), .fit_i(fit),
      .val_i(val), .pin_o(pin_w));

   function automatic logic [15:0] ecfg(input logic [11:0] r);
      return {2'h0, r[2:0], r[5:3], r[10:9], r[11], ~r[6], ~r[7], ~r[8], 2'h0};
   endfunction

   function automatic logic [15:0] estat(input logic [11:0] r);
      return {4'h0, r[10:9] == 2'h3, ~r[8], ~r[7], r[6], r[5:3], 2'h0,
         r[2:0]};
   endfunction

   task automatic final_report;
      if (n_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   // Board flips after release: the held straps must not follow
   task automatic run_row(input logic [11:0] r, input logic [8:0] f);
      logic [15:0] d;
      @(posedge clk_i);
      fit <= f;
      val <= r[8:0];
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // Cycle after the last reset edge: pins still released
      #1 chk({7'h0, oe_v}, 16'h0000);
      @(posedge clk_i);
      #1 chk(cfg, ecfg(r));
      chk({7'h0, oe_v}, 16'h01ff);
      @(posedge clk_i);
      val <= ~r[8:0];
      #1 chk({7'h0, pin_w}, 16'h011d);
      repeat (3) @(posedge clk_i);
      #1 chk(cfg, ecfg(r));
      rd(PSOL_REG_STRAP_STAT, d);
      chk(d, estat(r));
      rd(PSOL_REG_BASIC_CTRL, d);
      chk(d, {3'h0, ~r[6], 12'h000});
   endtask

   initial begin
      logic [15:0] d;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         run_row(rows[i], (i == 0) ? 9'h000 : 9'h1ff);
      end
      wr(PSOL_REG_STRAP_STAT, 16'hffff);
      rd(PSOL_REG_STRAP_STAT, d);
      chk(d, estat(rows[7]));
      wr(PSOL_REG_BASIC_CTRL, 16'h0000);
      #1 chk({15'h0, an_o}, 16'h0000);
      wr(PSOL_REG_BASIC_CTRL, 16'h1a5a);
      rd(PSOL_REG_BASIC_CTRL, d);
      chk(d, 16'h1a5a);
      rd(5'h07, d);
      chk(d, 16'h0000);
      chk(cfg, ecfg(rows[7]));
      @(posedge clk_i);
      rx_d <= 4'h5;
      rx_c <= 1'b0;
      rx_v <= 1'b1;
      rx_e <= 1'b0;
      crs <= 1'b0;
      irq <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk({7'h0, o_v}, 16'h0062);
      chk({7'h0, oe_v}, 16'h017f);
      final_report;
   end

   // Full run is well under 200 cycles
   initial begin
      #200000;
      n_errors++;
      final_report;
   end
endmodule

`default_nettype wire
